// File: core/asi_pkg.sv
package asi_pkg;

	// address tuple widths
	localparam int ASI_W     = 8;   // space identifier width
	localparam int OFFSET_W  = 64;  // byte offset width
	localparam int CTX_W     = 13;  // context identifier width
	localparam int PART_W    = 8;   // partition identifier width
	localparam int TRAP_W    = 3;   // trap depth width

	// field position of the restriction bit
	localparam int ASI_OPEN_BIT = 7;

	// well-known identifiers (index values of the space catalogue)
	localparam logic [7:0] FIRST_SPACE_ID           = 8'h80;
	localparam logic [7:0] SECOND_SPACE_ID          = 8'h81;
	localparam logic [7:0] FIRST_SPACE_QUIET_LOAD_ID = 8'h82;
	localparam logic [7:0] FIRST_SPACE_ID_LE        = 8'h88;
	localparam logic [7:0] KERNEL_SPACE_ID          = 8'h04;
	localparam logic [7:0] KERNEL_SPACE_ID_LE       = 8'h0c;
	localparam logic [7:0] USER_VIEW_FIRST_SPACE_ID = 8'h10;

	// bounds of the restricted-to-hyper band
	localparam logic [7:0] HYPER_BAND_LO = 8'h30;
	localparam logic [7:0] HYPER_BAND_HI = 8'h7f;

	// reset value and privileged trap depth limit
	localparam logic [2:0] TRAP_DEPTH_RST = 3'h0;
	localparam logic [2:0] MAX_PRIV_TRAP_DEPTH = 3'h2;

	// privilege modes
	typedef enum logic [1:0] {
		MODE_USER,
		MODE_PRIV,
		MODE_HYPER
	} mode_t;

	// kinds of reference from the pipeline
	typedef enum logic [1:0] {
		REF_FETCH,
		REF_LOAD,
		REF_STORE,
		REF_PREFETCH
	} ref_kind_t;

	// processor state that picks implicit spaces
	typedef struct packed {
		logic       privileged_mode_bit;
		logic       hyper_mode_bit;
		logic       little_endian_default_flag;
		logic [2:0] trap_depth;
	} cpu_state_t;

	// one reference from the pipeline
	typedef struct packed {
		logic            valid;
		ref_kind_t       kind;
		logic            alternate;   // explicit space reference
		logic            reg_reg;     // register+register addressing
		logic [7:0]      inst_asi;    // identifier field of instruction
		logic            use_second;  // secondary context select
		logic [63:0]     offset;
	} mem_req_t;

endpackage

// File: core/asi_mode_decode.sv
`timescale 1ns/10ps
// privilege mode decode, hyper bit dominates
module asi_mode_decode (
	input  wire logic              privileged_mode_bit_in,
	input  wire logic              hyper_mode_bit_in,
	output asi_pkg::mode_t         mode_out
);

	// hyper wins, then privileged, else user
	always_comb begin
		if (hyper_mode_bit_in) begin
			mode_out = asi_pkg::MODE_HYPER;
		end else if (privileged_mode_bit_in) begin
			mode_out = asi_pkg::MODE_PRIV;
		end else begin
			mode_out = asi_pkg::MODE_USER;
		end
	end

endmodule // asi_mode_decode

// File: core/asi_access_check.sv
`timescale 1ns/10ps
// identifier legality against the current mode
module asi_access_check (
	input  wire logic [7:0]        asi_in,
	input  asi_pkg::mode_t         mode_in,
	output logic                   fault_out
);

	logic open_band;   // unrestricted identifiers
	logic hyper_band;  // restricted to hyper

	assign open_band  = asi_in[asi_pkg::ASI_OPEN_BIT];
	assign hyper_band = (asi_in >= asi_pkg::HYPER_BAND_LO) &&
		(asi_in <= asi_pkg::HYPER_BAND_HI);

	// decide fault per mode
	always_comb begin
		fault_out = 1'b0;
		case (mode_in)
			asi_pkg::MODE_USER: begin
				fault_out = !open_band;
			end
			asi_pkg::MODE_PRIV: begin
				// low band 00-2f stays legal here
				fault_out = hyper_band;
			end
			default: begin
				fault_out = 1'b0;
			end
		endcase
	end

endmodule // asi_access_check

// File: core/address_space_select_check.sv
`timescale 1ns/10ps
// Operation
// - every address carries eight-bit space identifier
// - offset is 64-bit byte address
// - real address is context above virtual
// - physical is partition above real address
// - context comes from primary or secondary register
// - partition register width is a parameter
// - alternate data operations use their explicit identifier
// - reg+reg from instruction, reg+imm from register
// - fetch identifier from mode and trap depth
// - depth zero uses first space, le variant
// - privileged nonzero depth fetches use kernel space
// - privileged nonzero depth data uses kernel, le
// - hyper mode implicit references are physical
// - user mode faults on identifier bit7 zero
// - privileged mode faults on 30 to 7f
// - 80 to ff legal in every mode
// - 00 to 2f legal privileged or hyper
// - 30 to 7f legal only in hyper
module address_space_select_check #(
	parameter int CTX_W  = asi_pkg::CTX_W,   // context id width
	parameter int PART_W = asi_pkg::PART_W   // partition register width
) (
	input  wire logic                       mclk_in,
	input  wire logic                       rst_in,
	input  wire asi_pkg::cpu_state_t        state_in,
	input  wire asi_pkg::mem_req_t          req_in,
	input  wire logic [7:0]                 asi_reg_in,
	input  wire logic [CTX_W-1:0]           first_ctx_in,
	input  wire logic [CTX_W-1:0]           second_ctx_in,
	input  wire logic [PART_W-1:0]          partition_in,
	output logic                            valid_out,
	output logic [7:0]                      asi_out,
	output logic [63:0]                     offset_out,
	output logic                            physical_out,
	output logic [CTX_W+63:0]               real_addr_out,
	output logic [PART_W+CTX_W+63:0]        phys_addr_out,
	output logic                            priv_action_out
);

	// widths the logic cannot serve
	initial begin
		if (CTX_W < 1 || PART_W < 1) begin
			$error("context and partition widths must be positive");
		end
	end

	asi_pkg::mode_t      mode;        // decoded privilege mode
	logic [7:0]          sel_asi;     // chosen identifier
	logic                sel_phys;    // implicit hyper reference
	logic                fault;       // access check result
	logic [CTX_W-1:0]    sel_ctx;     // chosen context id
	logic                is_data;     // load, store or prefetch
	logic                depth_zero;  // trap depth at zero

	// mode decode
	asi_mode_decode u_mode (
		.privileged_mode_bit_in (state_in.privileged_mode_bit),
		.hyper_mode_bit_in      (state_in.hyper_mode_bit),
		.mode_out               (mode)
	);

	assign is_data    = (req_in.kind != asi_pkg::REF_FETCH);
	assign depth_zero = (state_in.trap_depth == asi_pkg::TRAP_DEPTH_RST);

	// identifier selection, explicit first then implicit
	always_comb begin
		sel_asi  = asi_pkg::FIRST_SPACE_ID;
		sel_phys = 1'b0;
		if (req_in.alternate && is_data) begin
			// explicit identifier, source set by addressing mode
			if (req_in.reg_reg) begin
				sel_asi = req_in.inst_asi;
			end else begin
				sel_asi = asi_reg_in;
			end
		end else if (mode == asi_pkg::MODE_HYPER) begin
			// hyper: implicit refs bypass translation at any depth
			sel_asi  = asi_pkg::FIRST_SPACE_ID;
			sel_phys = 1'b1;
		end else if (!is_data) begin
			// fetches ignore the endian flag
			if (depth_zero || mode == asi_pkg::MODE_USER) begin
				sel_asi = asi_pkg::FIRST_SPACE_ID;
			end else begin
				sel_asi = asi_pkg::KERNEL_SPACE_ID;
			end
		end else if (depth_zero || mode == asi_pkg::MODE_USER) begin
			sel_asi = state_in.little_endian_default_flag ?
				asi_pkg::FIRST_SPACE_ID_LE :
				asi_pkg::FIRST_SPACE_ID;
		end else begin
			sel_asi = state_in.little_endian_default_flag ?
				asi_pkg::KERNEL_SPACE_ID_LE :
				asi_pkg::KERNEL_SPACE_ID;
		end
	end

	// only explicit identifiers are policed
	asi_access_check u_check (
		.asi_in   (sel_asi),
		.mode_in  (mode),
		.fault_out(fault)
	);

	// context source register
	assign sel_ctx = req_in.use_second ? second_ctx_in : first_ctx_in;

	// registered address tuple; one cycle latency
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			valid_out     <= 1'b0;
			asi_out       <= asi_pkg::FIRST_SPACE_ID;
			offset_out    <= '0;
			physical_out  <= 1'b0;
			real_addr_out <= '0;
			phys_addr_out <= '0;
		end else begin
			valid_out     <= req_in.valid;
			asi_out       <= sel_asi;
			offset_out    <= req_in.offset;
			physical_out  <= req_in.valid && sel_phys;
			real_addr_out <= {sel_ctx, req_in.offset};
			phys_addr_out <= {partition_in, sel_ctx,
				req_in.offset};
		end
	end

	// exception flag, a pulse beside the faulting reference
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			priv_action_out <= 1'b0;
		end else begin
			// implicit refs always pass; only explicit ones can trap
			priv_action_out <= req_in.valid && req_in.alternate &&
				is_data && fault;
		end
	end

endmodule // address_space_select_check

// File: sim/pipe_model.sv
`timescale 1ns/10ps
// pipeline stand-in: a fresh random reference every cycle
module pipe_model (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	output asi_pkg::cpu_state_t state_out,
	output asi_pkg::mem_req_t req_out,
	output logic [7:0]       asi_reg_out,
	output logic [33:0]      regs_out
);
	// band edges, where an off-by-one hides
	logic [7:0] cor [8] = '{8'h00, 8'h2f, 8'h30, 8'h7f, 8'h80, 8'hff,
		8'h2e, 8'h31};
	logic       hold_r; // reset as seen at the edge
	initial begin
		state_out = '0;
		req_out = '0;
		asi_reg_out = 8'h80;
		regs_out = '0;
	end
	// idle fields still churn, so stale values never look right
	always @(posedge mclk_in) begin
		hold_r = rst_in;
		#1;
		state_out = asi_pkg::cpu_state_t'($urandom);
		req_out = asi_pkg::mem_req_t'({$urandom, $urandom, $urandom});
		req_out.valid = !hold_r && ($urandom % 4 != 0);
		if ($urandom % 2) req_out.inst_asi = cor[$urandom % 8];
		asi_reg_out = ($urandom % 2) ? cor[$urandom % 8] : 8'($urandom);
		regs_out = 34'({$urandom, $urandom});
	end
endmodule // pipe_model

// File: sim/asc_assertions.sv
`timescale 1ns/10ps
// port watcher; hyper bit outranks the privilege bit
module asc_assertions #(
	parameter int CTX_W  = 13,
	parameter int PART_W = 8
) (
	input wire logic       mclk_in,
	input wire logic       rst_in,
	input wire asi_pkg::cpu_state_t state_in,
	input wire asi_pkg::mem_req_t req_in,
	input wire logic [7:0] asi_reg_in,
	input wire logic [PART_W-1:0] partition_in,
	input wire logic       valid_out,
	input wire logic [7:0] asi_out,
	input wire logic [CTX_W+63:0] real_addr_out,
	input wire logic [PART_W+CTX_W+63:0] phys_addr_out,
	input wire logic       physical_out,
	input wire logic       priv_action_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire logic hyp_w = state_in.hyper_mode_bit; // hyper mode
	wire logic prv_w = state_in.privileged_mode_bit && !hyp_w;
	wire logic fet_w = req_in.kind == asi_pkg::REF_FETCH; // fetch
	wire logic alt_w = req_in.alternate && !fet_w; // explicit data
	// explicit data reference
	sequence alt_s;
		req_in.valid && alt_w;
	endsequence
	valid_copy_a: assert property (req_in.valid |=> valid_out)
		else $error("reference dropped");
	offset_low_a: assert property (req_in.valid |=>
		real_addr_out[63:0] == $past(req_in.offset)) else $error("offset");
	part_above_a: assert property (valid_out |->
		phys_addr_out == {$past(partition_in), real_addr_out})
		else $error("partition");
	user_fault_a: assert property (alt_s ##0 (!hyp_w && !prv_w &&
		req_in.reg_reg && !req_in.inst_asi[7]) |=> priv_action_out)
		else $error("user fault");
	priv_band_a: assert property (alt_s ##0 (prv_w && req_in.reg_reg &&
		req_in.inst_asi inside {[8'h30:8'h7f]}) |=> priv_action_out)
		else $error("band fault");
	open_band_a: assert property (alt_s ##0 (req_in.reg_reg &&
		req_in.inst_asi[7]) |=> !priv_action_out) else $error("open");
	hyper_pass_a: assert property (hyp_w |=> !priv_action_out)
		else $error("hyper fault");
	imm_source_a: assert property (alt_s ##0 !req_in.reg_reg |=>
		asi_out == $past(asi_reg_in)) else $error("id register");
	hyper_phys_a: assert property (req_in.valid && hyp_w && !alt_w
		|=> physical_out) else $error("physical");
	kernel_fetch_a: assert property (req_in.valid && fet_w && prv_w &&
		state_in.trap_depth != 0 |=> asi_out == asi_pkg::KERNEL_SPACE_ID)
		else $error("kernel fetch");
endmodule // asc_assertions
bind address_space_select_check asc_assertions #(.CTX_W(CTX_W),
	.PART_W(PART_W)) chk_u (.mclk_in, .rst_in, .state_in, .req_in,
	.asi_reg_in, .partition_in, .valid_out, .asi_out, .real_addr_out,
	.phys_addr_out, .physical_out, .priv_action_out);

// File: sim/testbench.sv
`timescale 1ns/10ps
// random references checked against a reference selector
module testbench;
	logic mclk_in = 1'b0; // core clock
	logic rst_in = 1'b1; // sync reset
	asi_pkg::cpu_state_t st; // mode and depth
	asi_pkg::mem_req_t rq; // pipeline reference
	logic [7:0] ar; // identifier register
	logic [33:0] rg; // first, second, partition
	logic valid_out, physical_out, priv_action_out, v;
	logic [7:0] asi_out;
	logic [63:0] offset_out; // byte offset within the space
	logic [76:0] real_addr_out;
	logic [84:0] phys_addr_out, ep;
	logic [9:0] e; // physical, fault, id
	int error_cnt = 0;
	int n_tests = 0;
	always #12.5 mclk_in = ~mclk_in;
	pipe_model pipe_u (.mclk_in, .rst_in, .state_out(st), .req_out(rq),
		.asi_reg_out(ar), .regs_out(rg));
	address_space_select_check dut_u (.mclk_in, .rst_in, .state_in(st),
		.req_in(rq), .asi_reg_in(ar), .first_ctx_in(rg[33:21]),
		.second_ctx_in(rg[20:8]), .partition_in(rg[7:0]), .valid_out,
		.asi_out, .offset_out, .physical_out, .real_addr_out,
		.phys_addr_out, .priv_action_out);
	// expected identifier, fault and physical flag
	function automatic logic [9:0] exp_f(asi_pkg::cpu_state_t s,
		asi_pkg::mem_req_t r, logic [7:0] a);
		logic d;
		logic h;
		d = r.kind != asi_pkg::REF_FETCH;
		h = s.hyper_mode_bit;
		if (d && r.alternate) begin
			if (r.reg_reg) a = r.inst_asi;
			return {1'b0, !h && (s.privileged_mode_bit ?
				a inside {[8'h30:8'h7f]} : !a[7]), a};
		end
		if (h) return {2'b10, asi_pkg::FIRST_SPACE_ID};
		d = d && s.little_endian_default_flag;
		if (s.trap_depth == 0 || !s.privileged_mode_bit)
			return {2'b00, d ? asi_pkg::FIRST_SPACE_ID_LE : 8'h80};
		return {2'b00, d ? asi_pkg::KERNEL_SPACE_ID_LE : 8'h04};
	endfunction
	task automatic chk(string n, logic [84:0] s, logic [84:0] x);
		n_tests++;
		if (s !== x) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// about 3000 cycles expected, so 4000 is a hang
	initial begin
		#100000;
		error_cnt++;
		end_sim;
	end
	initial begin
		void'($urandom(32'hb2b9));
		repeat (12) @(posedge mclk_in);
		#1;
		chk("reset id", asi_out, 8'h80);
		rst_in = 1'b0;
		repeat (3000) begin
			@(posedge mclk_in);
			e = exp_f(st, rq, ar);
			ep = {rg[7:0], rq.use_second ? rg[20:8] : rg[33:21], rq.offset};
			v = rq.valid;
			#2;
			chk("valid", valid_out, v);
			if (v) begin
				chk("id", asi_out, e[7:0]);
				chk("fault", priv_action_out, e[8]);
				chk("physical", physical_out, e[9]);
				chk("offset", offset_out, ep[63:0]);
				chk("real", real_addr_out, ep[76:0]);
				chk("full", phys_addr_out, ep);
			end
		end
		end_sim;
	end
endmodule // testbench
